//--- rtl/psm_pkg.sv
// shared constants and types for the pin state mode controller
package psm_pkg;

    // pin group widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int PORT_W = 8;
    localparam int STRB_W = 4;
    localparam int AXI_AW = 8;
    localparam int SYNC_W = PORT_W + 2;

    // register byte offsets
    localparam logic [AXI_AW-1:0] OFS_SYSCTL    = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_PORT_DATA = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_PORT_DIR  = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_STATUS    = 8'h0C;

    // system control register fields
    localparam int SYS_W        = 3;
    localparam int SYS_ONCHIP_RAM_ENABLE_BIT_BIT = 0;
    localparam int SYS_BUS_RELEASE_ENABLE_BIT = 1;
    localparam int SYS_SSBY_BIT = 2;

    // status register fields
    localparam int ST_PIN_LSB  = 0;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_STANDBY_IN_N_BIT = 11;
    localparam int ST_RST_BIT  = 12;

    // values after reset
    localparam logic [SYS_W-1:0]  SYSCTL_RESET    = 3'h1;
    localparam logic [PORT_W-1:0] PORT_DATA_RESET = 8'h00;
    localparam logic [PORT_W-1:0] PORT_DIR_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET      = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RESET      = 16'h0000;
    localparam logic [STRB_W-1:0] STRB_IDLE       = 4'hF;
    localparam logic [SYNC_W-1:0] SYNC_RESET      = 10'h300;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // state of the external bus access in progress
    typedef enum logic [2:0] {
        BS_IDLE,
        BS_T1,
        BS_T2,
        BS_T3,
        BS_TW
    } psm_bus_state_t;

    // pin state mode
    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_RUN,
        MODE_SW_STANDBY_IN_N,
        MODE_BUS_REL,
        MODE_HW_STANDBY_IN_N
    } psm_mode_t;

endpackage : psm_pkg

//--- rtl/psm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psm_sync
    import psm_pkg::*;
#(
    parameter int                WIDTH     = SYNC_W,
    parameter logic [WIDTH-1:0]  RESET_VAL = SYNC_RESET
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    // data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RESET_VAL;
            q_o  <= RESET_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule : psm_sync

//--- rtl/psm_top.sv
// pin state control across reset, standby, bus release and run modes
//
// Summary of operation
// - reset pin low makes all general ports inputs at once, no clock needed.
// - reset pin low drives all four strobes high and floats the data bus.
// - reset in first or second bus state: address low half a state after sampling.
// - reset pin is sampled on the falling clock edge.
// - reset in an inserted wait state times the address like second state.
// - reset in third bus state holds address until that state ends.
// - reset in second state of a two-state access behaves like third state.
// - in keep states inputs float, port outputs hold their last level, address, data and strobes float.
`timescale 1ns/1ps
module psm_top
    import psm_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // control pins
    input  wire logic                  reset_in_n_i,
    input  wire logic                  standby_in_n_i,
    input  wire logic                  bus_request_n_i,
    // bus controller side
    input  wire psm_bus_state_t        bus_state_i,
    input  wire logic                  two_state_access_i,
    input  wire logic [ADDR_W-1:0]     addr_i,
    input  wire logic [DATA_W-1:0]     data_i,
    input  wire logic                  data_oe_i,
    input  wire logic [STRB_W-1:0]     strobe_n_i,
    // external bus pins
    output logic      [ADDR_W-1:0]     addr_o,
    output logic                       addr_oe_o,
    output logic      [DATA_W-1:0]     data_o,
    output logic                       data_oe_o,
    output logic      [STRB_W-1:0]     strobe_n_o,
    output logic                       strobe_oe_o,
    output logic                       bus_grant_n_o,
    output logic                       bus_grant_oe_o,
    output logic                       clk_out_oe_o,
    output logic                       clk_out_hold_o,
    // general port pins
    input  wire logic [PORT_W-1:0]     port_i,
    output logic      [PORT_W-1:0]     port_o,
    output logic      [PORT_W-1:0]     port_oe_o,
    // axi4-lite slave
    input  wire logic [AXI_AW-1:0]     s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic      [1:0]            s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [AXI_AW-1:0]     s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic      [31:0]           s_axi_rdata_o,
    output logic      [1:0]            s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i
);

    function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
        return (a == OFS_SYSCTL) || (a == OFS_PORT_DATA) ||
               (a == OFS_PORT_DIR) || (a == OFS_STATUS);
    endfunction : is_mapped

    logic                pin_rst_raw_n;
    logic                rel_meta;
    logic                port_rst_n;
    logic                rst_meta_n;
    logic                rst_seen_n;
    logic                rst_seen_p;
    logic                rst_event;
    logic                addr_hold_case;
    logic                addr_pend;
    logic [SYNC_W-1:0]   sync_q;
    logic                standby_in_n_s_n;
    logic                bus_request_n_s_n;
    logic [PORT_W-1:0]   port_s;
    psm_mode_t           mode;
    psm_mode_t           next_mode;
    logic                run;
    logic                keep;
    logic [SYS_W-1:0]    sysctl;
    logic [PORT_W-1:0]   port_data;
    logic [PORT_W-1:0]   port_dir;
    logic                aw_got;
    logic                w_got;
    logic [AXI_AW-1:0]   awaddr_q;
    logic [31:0]         wdata_q;
    logic                wstrb0_q;
    logic                aw_fire;
    logic                w_fire;
    logic                do_write;
    logic                wr_en;
    logic [31:0]         rd_mux;
    logic [31:0]         status;

    // pin reset: asserts at once, releases through two flops
    assign pin_rst_raw_n = rst_n_i & reset_in_n_i;

    always_ff @(posedge ref_clk_i or negedge pin_rst_raw_n) begin
        if (!pin_rst_raw_n) begin
            rel_meta   <= 1'b0;
            port_rst_n <= 1'b0;
        end else begin
            rel_meta   <= 1'b1;
            port_rst_n <= rel_meta;
        end
    end

    // reset level taken on the falling clock edge
    always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_seen_n <= 1'b0;
        end else begin
            rst_meta_n <= reset_in_n_i;
            rst_seen_n <= rst_meta_n;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_seen_p <= 1'b0;
        end else begin
            rst_seen_p <= rst_seen_n;
        end
    end

    // first rising edge after the sampled low: half a state later
    assign rst_event      = rst_seen_p & ~rst_seen_n;
    assign addr_hold_case = (bus_state_i == BS_T3) ||
                            ((bus_state_i == BS_T2) && two_state_access_i);

    psm_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_RESET)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       ({standby_in_n_i, bus_request_n_i, port_i}),
        .q_o       (sync_q)
    );

    assign standby_in_n_s_n = sync_q[SYNC_W-1];
    assign bus_request_n_s_n = sync_q[SYNC_W-2];
    assign port_s   = sync_q[PORT_W-1:0];

    // mode selection, hardware standby first
    assign next_mode = !standby_in_n_s_n   ? MODE_HW_STANDBY_IN_N :
                       !rst_seen_n ? MODE_RESET :
                       (sysctl[SYS_BUS_RELEASE_ENABLE_BIT] && !bus_request_n_s_n &&
                        (mode == MODE_RUN || mode == MODE_BUS_REL)) ? MODE_BUS_REL :
                       sysctl[SYS_SSBY_BIT] ? MODE_SW_STANDBY_IN_N : MODE_RUN;
    assign run  = (mode == MODE_RUN);
    assign keep = (mode == MODE_SW_STANDBY_IN_N) || (mode == MODE_BUS_REL);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode <= MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // address bus
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o    <= ADDR_RESET;
            addr_oe_o <= 1'b1;
            addr_pend <= 1'b0;
        end else if (mode == MODE_HW_STANDBY_IN_N) begin
            addr_oe_o <= 1'b0;
            addr_pend <= 1'b0;
        end else if (rst_event && !addr_hold_case) begin
            addr_o    <= ADDR_RESET;
            addr_oe_o <= 1'b1;
        end else if (rst_event) begin
            addr_pend <= 1'b1;
        end else if (addr_pend) begin
            addr_o    <= ADDR_RESET;
            addr_oe_o <= 1'b1;
            addr_pend <= 1'b0;
        end else if (run) begin
            addr_o    <= addr_i;
            addr_oe_o <= 1'b1;
        end else if (keep) begin
            addr_oe_o <= 1'b0;
        end
    end

    // outputs forced safe by the pin reset without a clock
    always_ff @(posedge ref_clk_i or negedge port_rst_n) begin
        if (!port_rst_n) begin
            port_oe_o      <= '0;
            data_oe_o      <= 1'b0;
            strobe_n_o     <= STRB_IDLE;
            bus_grant_oe_o <= 1'b0;
        end else begin
            port_oe_o      <= (run || keep) ? port_dir : '0;
            data_oe_o      <= run & data_oe_i;
            strobe_n_o     <= run ? strobe_n_i : STRB_IDLE;
            bus_grant_oe_o <= (mode == MODE_BUS_REL) ||
                              (sysctl[SYS_BUS_RELEASE_ENABLE_BIT] && (run || mode == MODE_SW_STANDBY_IN_N));
        end
    end

    // held values and enables on the power-on reset only
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_o         <= PORT_DATA_RESET;
            data_o         <= DATA_RESET;
            strobe_oe_o    <= 1'b1;
            bus_grant_n_o  <= 1'b1;
            clk_out_oe_o   <= 1'b1;
            clk_out_hold_o <= 1'b0;
        end else begin
            port_o         <= run ? port_data : port_o;
            data_o         <= run ? data_i : data_o;
            strobe_oe_o    <= run || (mode == MODE_RESET);
            bus_grant_n_o  <= (mode != MODE_BUS_REL);
            clk_out_oe_o   <= (mode != MODE_HW_STANDBY_IN_N);
            clk_out_hold_o <= (mode == MODE_SW_STANDBY_IN_N);
        end
    end

    // axi4-lite write channel
    assign aw_fire  = s_axi_awvalid_i & s_axi_awready_o;
    assign w_fire   = s_axi_wvalid_i & s_axi_wready_o;
    assign do_write = aw_got & w_got & ~s_axi_bvalid_o;
    assign wr_en    = do_write & wstrb0_q & is_mapped(awaddr_q);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            awaddr_q        <= '0;
            wdata_q         <= '0;
            wstrb0_q        <= 1'b0;
        end else begin
            if (aw_fire) begin
                awaddr_q        <= s_axi_awaddr_i;
                aw_got          <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            if (w_fire) begin
                wdata_q        <= s_axi_wdata_i;
                wstrb0_q       <= s_axi_wstrb_i[0];
                w_got          <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write) begin
                aw_got         <= 1'b0;
                w_got          <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // software registers, loaded with their reset values by the pin reset as well
    always_ff @(posedge ref_clk_i or negedge port_rst_n) begin
        if (!port_rst_n) begin
            sysctl    <= SYSCTL_RESET;
            port_data <= PORT_DATA_RESET;
            port_dir  <= PORT_DIR_RESET;
        end else if (wr_en) begin
            if (awaddr_q == OFS_SYSCTL) begin
                sysctl <= wdata_q[SYS_W-1:0];
            end
            if (awaddr_q == OFS_PORT_DATA) begin
                port_data <= wdata_q[PORT_W-1:0];
            end
            if (awaddr_q == OFS_PORT_DIR) begin
                port_dir <= wdata_q[PORT_W-1:0];
            end
        end
    end

    // axi4-lite read channel
    assign status = {19'h00000, ~rst_seen_n, ~standby_in_n_s_n, mode, port_s};
    assign rd_mux = (s_axi_araddr_i == OFS_SYSCTL)    ? {29'h00000000, sysctl} :
                    (s_axi_araddr_i == OFS_PORT_DATA) ? {24'h000000, port_data} :
                    (s_axi_araddr_i == OFS_PORT_DIR)  ? {24'h000000, port_dir} :
                    (s_axi_araddr_i == OFS_STATUS)    ? status : 32'h00000000;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_mux;
            s_axi_rresp_o   <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end
    end

    chk_reset_ports_in: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !reset_in_n_i |-> port_oe_o == '0)
        else $error("ports not inputs while reset pin low");

    chk_reset_strobes_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !reset_in_n_i |-> (strobe_n_o == STRB_IDLE) && !data_oe_o)
        else $error("strobes or data bus wrong while reset pin low");

    chk_reset_fall_sample: assert property (@(negedge ref_clk_i) disable iff (!rst_n_i)
        $fell(rst_seen_n) |-> !$past(reset_in_n_i, 2))
        else $error("reset seen without a low sample two falling edges back");

    chk_addr_early_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rst_event && mode != MODE_HW_STANDBY_IN_N &&
        (bus_state_i == BS_T1 || (bus_state_i == BS_T2 && !two_state_access_i))
        |=> addr_oe_o && addr_o == ADDR_RESET)
        else $error("address not low half a state after reset sample");

    chk_addr_wait_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rst_event && mode != MODE_HW_STANDBY_IN_N && bus_state_i == BS_TW
        |=> addr_oe_o && addr_o == ADDR_RESET)
        else $error("reset in wait state did not lower address");

    chk_addr_third_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rst_event && mode != MODE_HW_STANDBY_IN_N && next_mode != MODE_HW_STANDBY_IN_N &&
        bus_state_i == BS_T3
        |=> $stable(addr_o) ##1 addr_o == ADDR_RESET)
        else $error("address not held through third state");

    chk_addr_two_state: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rst_event && mode != MODE_HW_STANDBY_IN_N && next_mode != MODE_HW_STANDBY_IN_N &&
        bus_state_i == BS_T2 && two_state_access_i
        |=> $stable(addr_o) ##1 addr_o == ADDR_RESET)
        else $error("two-state access reset not held like third state");

    chk_keep_port_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        keep && $past(keep) |-> $stable(port_o))
        else $error("port output changed in a keep state");

    chk_hw_standby_in_n_float: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mode == MODE_HW_STANDBY_IN_N ##1 mode == MODE_HW_STANDBY_IN_N |->
        !clk_out_oe_o && !addr_oe_o && !data_oe_o && !strobe_oe_o && port_oe_o == '0)
        else $error("pin driven in hardware standby");

    chk_bus_rel_float: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        mode == MODE_BUS_REL |=>
        !bus_grant_n_o && bus_grant_oe_o && !addr_oe_o && !data_oe_o && !strobe_oe_o)
        else $error("bus release pin states wrong");

endmodule : psm_top

//--- verif/psm_ctrl_model.sv
// model of the external reset and standby controller
`timescale 1ns/1ps
module psm_ctrl_model (
    // clock
    input  wire logic ref_clk_i,
    // control pins
    output logic      reset_in_n_o,
    output logic      standby_in_n_o
);
    initial begin
        reset_in_n_o   = 1'b1;
        standby_in_n_o = 1'b1;
    end

    task automatic drive_reset(input logic v);
        @(posedge ref_clk_i);
        reset_in_n_o <= v;
    endtask : drive_reset

    // reset first only when ram contents must survive
    task automatic enter_hw_standby(input logic keep_ram);
        @(posedge ref_clk_i);
        if (keep_ram) begin
            reset_in_n_o <= 1'b0;
            repeat (10) @(posedge ref_clk_i);
        end
        standby_in_n_o <= 1'b0;
    endtask : enter_hw_standby

    // reset low four clocks of 25 ns before standby rises
    task automatic leave_hw_standby();
        @(posedge ref_clk_i);
        reset_in_n_o <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        standby_in_n_o <= 1'b1;
        @(posedge ref_clk_i);
        reset_in_n_o <= 1'b1;
    endtask : leave_hw_standby
endmodule : psm_ctrl_model

//--- verif/test_psm_top.sv
// self-checking bench for the pin state mode controller
`timescale 1ns/1ps
module test_psm_top;
    import psm_pkg::*;

    logic                ref_clk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    logic                reset_in_n_i, standby_in_n_i;
    logic                bus_request_n_i = 1'b1;
    psm_bus_state_t      bus_state_i = BS_IDLE;
    logic                two_state_access_i = 1'b0;
    logic [ADDR_W-1:0]   addr_i = 24'hABCDEF;
    logic [DATA_W-1:0]   data_i = 16'h1234;
    logic                data_oe_i = 1'b1;
    logic [STRB_W-1:0]   strobe_n_i = 4'h0;
    logic [PORT_W-1:0]   port_i = 8'h3C;
    logic [ADDR_W-1:0]   addr_o;
    logic [DATA_W-1:0]   data_o;
    logic [STRB_W-1:0]   strobe_n_o;
    logic [PORT_W-1:0]   port_o, port_oe_o;
    logic                addr_oe_o, data_oe_o, strobe_oe_o, bus_grant_n_o, bus_grant_oe_o;
    logic                clk_out_oe_o, clk_out_hold_o;
    logic [AXI_AW-1:0]   s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0]         s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
    logic [3:0]          s_axi_wstrb_i = 4'hF;
    logic [1:0]          s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic                s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic                s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic                s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic                s_axi_arready_o, s_axi_rvalid_o;
    int                  errors = 0, checks_done = 0;
    psm_bus_state_t      cs_st [5] = '{BS_T1, BS_T2, BS_TW, BS_T3, BS_T2};
    logic [4:0]          cs_two = 5'h10;
    logic [31:0]         hold_exp;

    always #12.5 ref_clk_i = ~ref_clk_i;

    psm_ctrl_model u_psm_ctrl_model (
        .ref_clk_i(ref_clk_i), .reset_in_n_o(reset_in_n_i), .standby_in_n_o(standby_in_n_i));

    psm_top u_psm_top (
        .ref_clk_i, .rst_n_i, .reset_in_n_i, .standby_in_n_i, .bus_request_n_i, .bus_state_i,
        .two_state_access_i, .addr_i, .data_i, .data_oe_i, .strobe_n_i, .addr_o, .addr_oe_o,
        .data_o, .data_oe_o, .strobe_n_o, .strobe_oe_o, .bus_grant_n_o, .bus_grant_oe_o,
        .clk_out_oe_o, .clk_out_hold_o, .port_i, .port_o, .port_oe_o, .s_axi_awaddr_i,
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, done;
        aw = 1'b1;
        w = 1'b1;
        done = 1'b0;
        @(posedge ref_clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        while (!done) begin
            @(posedge ref_clk_i);
            if (aw && s_axi_awready_o === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid_i <= 1'b0;
            end
            if (w && s_axi_wready_o === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid_i <= 1'b0;
            end
            if (!aw && !w && s_axi_bvalid_o === 1'b1) begin
                done = 1'b1;
                r = s_axi_bresp_o;
                s_axi_bready_i <= 1'b0;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge ref_clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        while (!done) begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1) begin
                done = 1'b1;
                d = s_axi_rdata_o;
                r = s_axi_rresp_o;
                s_axi_rready_i <= 1'b0;
            end
        end
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask : wr

    // poll the status mode field until run
    task automatic wait_run();
        do axi_rd(OFS_STATUS, rd, rsp);
        while (rd[ST_MODE_LSB +: 3] !== 3'(MODE_RUN));
    endtask : wait_run

    initial begin
        #200000;
        errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_run();
        chk(32'(rd[ST_PIN_LSB +: 8]), 32'h3C);
        axi_rd(OFS_SYSCTL, rd, rsp);
        chk(rd, 32'(SYSCTL_RESET));
        axi_rd(8'h10, rd, rsp);
        chk({rd[29:0], rsp}, 32'h2);
        axi_wr(8'h10, 32'h1, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        chk(32'(data_o), 32'h1234);
        // reset pin drop in each bus state of an access
        for (int i = 0; i < 5; i++) begin
            wr(OFS_PORT_DIR, 32'hFE);
            bus_state_i        <= cs_st[i];
            two_state_access_i <= cs_two[i];
            @(posedge ref_clk_i);
            chk({port_oe_o, 7'h0, data_oe_o, strobe_n_o}, 32'h000FE010);
            u_psm_ctrl_model.drive_reset(1'b0);
            #1;
            chk(32'(port_oe_o), 32'h0);
            chk({data_oe_o, strobe_n_o}, 32'(STRB_IDLE));
            @(posedge ref_clk_i);
            #1;
            chk(32'(addr_o), 32'hABCDEF);
            @(posedge ref_clk_i);
            #1;
            hold_exp = (cs_st[i] == BS_T3 || cs_two[i]) ? 32'hABCDEF : 32'h0;
            chk(32'(addr_o), hold_exp);
            @(posedge ref_clk_i);
            #1;
            chk(32'(addr_o), 32'h0);
            u_psm_ctrl_model.drive_reset(1'b1);
            wait_run();
        end
        bus_state_i <= BS_IDLE;
        // bus release keeps ports, floats bus
        wr(OFS_SYSCTL, 32'h3);
        wr(OFS_PORT_DIR, 32'hFE);
        wr(OFS_PORT_DATA, 32'h5A);
        bus_request_n_i <= 1'b0;
        while (bus_grant_n_o !== 1'b0) @(posedge ref_clk_i);
        chk({addr_oe_o, data_oe_o, strobe_oe_o, bus_grant_oe_o, clk_out_oe_o}, 32'h3);
        chk({port_oe_o, port_o}, 32'hFE5A);
        axi_rd(OFS_STATUS, rd, rsp);
        chk(32'(rd[ST_MODE_LSB +: 3]), 32'(MODE_BUS_REL));
        bus_request_n_i <= 1'b1;
        // software standby keeps ports
        wr(OFS_SYSCTL, 32'h5);
        while (clk_out_hold_o !== 1'b1) @(posedge ref_clk_i);
        chk({addr_oe_o, port_oe_o, port_o}, 32'hFE5A);
        wr(OFS_SYSCTL, 32'h1);
        // hardware standby, with and without ram retention
        for (int k = 1; k >= 0; k--) begin
            if (k == 0) wr(OFS_SYSCTL, 32'h0);
            wr(OFS_PORT_DIR, 32'hFE);
            u_psm_ctrl_model.enter_hw_standby(k[0]);
            while (clk_out_oe_o !== 1'b0) @(posedge ref_clk_i);
            chk({addr_oe_o, data_oe_o, strobe_oe_o, bus_grant_oe_o, port_oe_o}, 32'h0);
            axi_rd(OFS_STATUS, rd, rsp);
            chk(32'(rd[11:8]), 32'hC);
            u_psm_ctrl_model.leave_hw_standby();
            wait_run();
        end
        axi_rd(OFS_SYSCTL, rd, rsp);
        chk(rd, 32'(SYSCTL_RESET));
        summarize();
    end
endmodule : test_psm_top
